// >>> tbp_pkg.sv
// Constants shared by the timer buzzer and PWM output block
package tbp_pkg;
  // Register offsets on the plain register port
  localparam logic [1:0] OFF_CTRL   = 2'h0;
  localparam logic [1:0] OFF_COUNT  = 2'h1;
  localparam logic [1:0] OFF_RELOAD = 2'h2;
  localparam logic [1:0] OFF_STAT   = 2'h3;
  // Control register field positions
  localparam int CTRL_RUN   = 7;
  localparam int CTRL_RATE  = 4;
  localparam int CTRL_FAST  = 3;
  localparam int CTRL_EXT   = 2;
  localparam int CTRL_ALOAD = 1;
  localparam int CTRL_BUZ   = 0;
  // Status register field positions
  localparam int STAT_FLAG = 0;
  localparam int STAT_IEN  = 1;
  localparam int STAT_PWM  = 2;
  // Reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  // Overflow boundaries as low-bit masks
  localparam logic [7:0] MASK_256 = 8'hff;
  localparam logic [7:0] MASK_64  = 8'h3f;
  localparam logic [7:0] MASK_32  = 8'h1f;
  localparam logic [7:0] MASK_16  = 8'h0f;
  // Prescaler base terms: instruction clock /2..256, fast /1..128
  localparam logic [7:0] PRE_SLOW = 8'hff;
  localparam logic [7:0] PRE_FAST = 8'h7f;
endpackage : tbp_pkg

// >>> tbp_timer_out.sv
// Timer with buzzer and PWM outputs on a shared pin
//
// Function
// - Buzzer toggles each overflow, half overflow rate
// - Buzzer enable takes the shared pin
// - Buzzer disable returns pin, timer runs
// - Overflow flag and request kept with buzzer
// - PWM on pin only when running and enabled
// - PWM period starts high, ends low
// - Match of count and duty drives low
// - Overflow ends period, drives output high
// - Period or duty change waits next period
// - Two bits select 256, 64, 32, 16
// - Flag still set each PWM overflow
// - PWM enable takes the shared pin
// - PWM disable returns pin, timer runs
// - Fast select picks oscillator over instruction
// - External select counts event pin edges
// - PWM mode always reloads count at overflow
// - Reload writes buffered until next overflow
`timescale 1ns/1ps
`default_nettype none
module tbp_timer_out #(
  parameter int DW = 8
) (
  input  wire logic          clk,       // 200 MHz clock, fast source
  input  wire logic          resetn,    // Async reset, active low
  input  wire logic [1:0]    addr,      // Register address
  input  wire logic [DW-1:0] wdata,     // Write data
  input  wire logic          wr,        // Write strobe
  input  wire logic          rd,        // Read strobe
  output logic      [DW-1:0] rdata,     // Read data, cycle after rd
  input  wire logic          cpu_tick,  // Instruction clock enable
  input  wire logic          event_in,  // External event pin
  input  wire logic          gpio_out,  // GPIO level for the pin
  input  wire logic          gpio_oe,   // GPIO drive enable
  output logic               pin_out,   // Shared pin level
  output logic               pin_oe,    // Shared pin drive enable
  output logic               irq_req    // Overflow request
);
  if (DW != 8) begin : g_chk
    $error("tbp_timer_out serves an 8-bit timer only");
  end

  // Period mask from PWM state and the two resolution bits
  function automatic logic [7:0] pmask(input logic pwm,
                                       input logic aload,
                                       input logic buz);
    logic [7:0] m;
    m = tbp_pkg::MASK_256;
    if (pwm) begin
      unique case ({aload, buz})
        2'b00: m = tbp_pkg::MASK_256;
        2'b01: m = tbp_pkg::MASK_64;
        2'b10: m = tbp_pkg::MASK_32;
        2'b11: m = tbp_pkg::MASK_16;
      endcase
    end
    return m;
  endfunction : pmask

  // Compare two values on the low bits that the period mask keeps
  function automatic logic masked_eq(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input logic [7:0] m);
    return (a & m) == (b & m);
  endfunction : masked_eq

  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] count_reg, count_next;
  logic [7:0] buf_reg, buf_next;     // Holding buffer for writes
  logic [7:0] act_reg, act_next;     // Active duty, copied from the buffer at overflow
  logic [7:0] pre_reg, pre_next;
  logic [7:0] rdata_next;
  logic       flag_reg, flag_next;
  logic       ien_reg, ien_next;
  logic       pwm_en_reg, pwm_en_next;
  logic       pwm_reg, pwm_next;
  logic       buz_reg, buz_next;
  logic       ev_reg;
  logic       run, fast, ext, aload, buz_en;
  logic       ev_fall, src_tick, tick, ovf;
  logic [7:0] mask, pre_term;

  assign run    = ctrl_reg[tbp_pkg::CTRL_RUN];
  assign fast   = ctrl_reg[tbp_pkg::CTRL_FAST];
  assign ext    = ctrl_reg[tbp_pkg::CTRL_EXT];
  assign aload  = ctrl_reg[tbp_pkg::CTRL_ALOAD];
  assign buz_en = ctrl_reg[tbp_pkg::CTRL_BUZ];
  assign mask   = pmask(pwm_en_reg, aload, buz_en);

  // Clock source and prescaler terminal count
  always_comb begin
    logic [2:0] rate;
    rate     = ctrl_reg[tbp_pkg::CTRL_RATE +: 3];
    ev_fall  = ev_reg & ~event_in;
    src_tick = fast ? 1'b1 : cpu_tick;
    pre_term = (fast ? tbp_pkg::PRE_FAST : tbp_pkg::PRE_SLOW) >> rate;
    pre_next = pre_reg;
    // Cleared while stopped so a restart begins with a full step
    if (!run || ext) begin
      pre_next = 8'h00;
    end else if (src_tick) begin
      pre_next = (pre_reg == pre_term) ? 8'h00 : pre_reg + 8'h01;
    end
    // Event edges bypass the prescaler entirely
    if (ext) begin
      tick = run & ev_fall;
    end else begin
      tick = run & src_tick & (pre_reg == pre_term);
    end
    ovf = tick & masked_eq(count_reg, mask, mask);
  end

  // Counter, reload buffer, outputs and register writes
  always_comb begin
    ctrl_next   = ctrl_reg;
    count_next  = count_reg;
    buf_next    = buf_reg;
    act_next    = act_reg;
    flag_next   = flag_reg;
    ien_next    = ien_reg;
    pwm_en_next = pwm_en_reg;
    pwm_next    = pwm_reg;
    buz_next    = buz_reg;
    rdata_next  = 8'h00;
    if (ovf) begin
      act_next = buf_reg;
      if (pwm_en_reg || aload) begin
        count_next = buf_reg;
      end else begin
        count_next = 8'h00;
      end
    end else if (tick) begin
      count_next = count_reg + 8'h01;
    end
    // Period starts high; match ends the high part
    if (!pwm_en_reg || !run) begin
      pwm_next = 1'b1;
    end else if (ovf) begin
      pwm_next = 1'b1;
    end else if (masked_eq(count_reg, act_reg, mask)) begin
      pwm_next = 1'b0;
    end
    // Buzzer toggles per overflow, held low while off
    if (!buz_en || pwm_en_reg) begin
      buz_next = 1'b0;
    end else if (ovf) begin
      buz_next = ~buz_reg;
    end
    // Register writes; the count write wins over reload
    if (wr) begin
      unique case (addr)
        tbp_pkg::OFF_CTRL:   ctrl_next = wdata;
        tbp_pkg::OFF_COUNT:  count_next = wdata;
        tbp_pkg::OFF_RELOAD: buf_next = wdata;
        tbp_pkg::OFF_STAT: begin
          ien_next    = wdata[tbp_pkg::STAT_IEN];
          pwm_en_next = wdata[tbp_pkg::STAT_PWM];
          if (!wdata[tbp_pkg::STAT_FLAG]) begin
            flag_next = 1'b0;
          end
        end
      endcase
    end
    // Set after the write so an overflow beats a software clear
    if (ovf) begin
      flag_next = 1'b1;
    end
    if (rd) begin
      unique case (addr)
        tbp_pkg::OFF_CTRL:   rdata_next = ctrl_reg;
        tbp_pkg::OFF_COUNT:  rdata_next = count_reg;
        tbp_pkg::OFF_RELOAD: rdata_next = 8'h00;
        tbp_pkg::OFF_STAT:   rdata_next = {5'h00, pwm_en_reg,
                                           ien_reg, flag_reg};
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg   <= tbp_pkg::CTRL_RST;
      count_reg  <= tbp_pkg::COUNT_RST;
      buf_reg    <= tbp_pkg::RELOAD_RST;
      act_reg    <= tbp_pkg::RELOAD_RST;
      pre_reg    <= 8'h00;
      rdata      <= 8'h00;
      flag_reg   <= 1'b0;
      ien_reg    <= 1'b0;
      pwm_en_reg <= 1'b0;
      pwm_reg    <= 1'b1;
      buz_reg    <= 1'b0;
      ev_reg     <= 1'b0;         // No false edge right after reset
    end else begin
      ctrl_reg   <= ctrl_next;
      count_reg  <= count_next;
      buf_reg    <= buf_next;
      act_reg    <= act_next;
      pre_reg    <= pre_next;
      rdata      <= rdata_next;
      flag_reg   <= flag_next;
      ien_reg    <= ien_next;
      pwm_en_reg <= pwm_en_next;
      pwm_reg    <= pwm_next;
      buz_reg    <= buz_next;
      ev_reg     <= event_in;
    end
  end

  // Shared pin: PWM, then buzzer, else the GPIO setting
  always_comb begin
    if (pwm_en_reg) begin
      pin_out = run & pwm_reg;
      pin_oe  = 1'b1;
    end else if (buz_en) begin
      pin_out = buz_reg;
      pin_oe  = 1'b1;
    end else begin
      pin_out = gpio_out;
      pin_oe  = gpio_oe;
    end
    irq_req = flag_reg & ien_reg;
  end

  // Checks on the outputs and their causes
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Buzzer level follows the overflows, low when off or under PWM
  a_buz_toggle: assert property (
    ovf && buz_en && !pwm_en_reg && !wr |=> buz_reg != $past(buz_reg))
    else $error("buzzer did not toggle at overflow");
  a_buz_hold: assert property (
    buz_en && !pwm_en_reg && !ovf |=> $stable(buz_reg))
    else $error("buzzer moved between overflows");
  a_buz_off: assert property (!buz_en |=> !buz_reg)
    else $error("buzzer not low while off");
  a_buz_pwm_low: assert property (pwm_en_reg |=> !buz_reg)
    else $error("buzzer not held low under pwm");
  // Shared pin goes to PWM, then buzzer, else back to the GPIO setting
  a_buz_pin: assert property (
    buz_en && !pwm_en_reg |-> pin_oe && pin_out == buz_reg)
    else $error("buzzer not on shared pin");
  a_gpio_back: assert property (
    !buz_en && !pwm_en_reg |-> pin_oe == gpio_oe && pin_out == gpio_out)
    else $error("pin not returned to gpio");
  a_pwm_pin: assert property (
    pwm_en_reg |-> pin_oe && pin_out == (run && pwm_reg))
    else $error("pwm pin level wrong");
  a_pwm_stop: assert property (
    pwm_en_reg && !run |-> pin_oe && !pin_out)
    else $error("pwm shown while timer stopped");
  // Overflow flag and request
  a_flag_set: assert property (ovf |=> flag_reg)
    else $error("overflow did not set flag");
  a_flag_clear: assert property (
    wr && addr == tbp_pkg::OFF_STAT && !wdata[tbp_pkg::STAT_FLAG] && !ovf
    |=> !flag_reg)
    else $error("flag not cleared by software");
  a_irq_gate: assert property (irq_req == (flag_reg && ien_reg))
    else $error("request does not follow flag and enable");
  // PWM period: high from the overflow, low from the duty match on
  a_pwm_high: assert property (
    ovf && pwm_en_reg && run ##1 pwm_en_reg && run |-> pin_out)
    else $error("pwm not high after overflow");
  a_pwm_low: assert property (
    run && pwm_en_reg && !ovf && !wr
    && (count_reg & mask) == (act_reg & mask) |=> !pwm_reg)
    else $error("pwm not low at duty match");
  a_pwm_hold_low: assert property (
    run && pwm_en_reg && !ovf && !pwm_reg |=> !pwm_reg)
    else $error("pwm rose before period end");
  a_reload_cnt: assert property (
    ovf && pwm_en_reg && !wr |=> count_reg == $past(buf_reg))
    else $error("count not reloaded at overflow");
  // Active duty changes only at an overflow, from the holding buffer
  a_act_hold: assert property (!ovf |=> $stable(act_reg))
    else $error("active duty changed mid period");
  a_act_load: assert property (ovf |=> act_reg == $past(buf_reg))
    else $error("buffer not moved at overflow");
  // Overflow boundary and tick sources
  a_ovf_bound: assert property (
    ovf |-> (count_reg & mask) == mask)
    else $error("overflow at wrong boundary");
  a_ext_tick: assert property (ext && run |-> tick == ev_fall)
    else $error("event edge not counted");
  a_slow_gate: assert property (
    run && !ext && !fast && !cpu_tick |-> !tick)
    else $error("slow source ticked without instruction clock");

  // Main scenarios reached
  c_buz_run: cover property (ovf && buz_en ##1 buz_reg);
  c_pwm_match: cover property (pwm_en_reg && run && pwm_reg ##1 !pwm_reg);
  c_pwm_16: cover property (ovf && pwm_en_reg && mask == 8'h0f);
  c_pwm_256: cover property (ovf && pwm_en_reg && mask == 8'hff);
  c_ext_ovf: cover property (ext && ovf);
endmodule : tbp_timer_out
`default_nettype wire

// >>> tbp_timer_out_bench.sv
// Self-checking bench for the timer buzzer and PWM output block
`timescale 1ns/1ps
`default_nettype none
module tbp_timer_out_bench;
  logic       clk;
  logic       resetn;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       cpu_tick;
  logic       event_in;
  logic       gpio_out;
  logic       gpio_oe;
  logic       pin_out;
  logic       pin_oe;
  logic       irq_req;
  int         err_count = 0;
  int         check_count = 0;
  int         cycles = 0;
  int         n;
  logic [7:0] d;
  logic [7:0] d2;
  int         exp_p [4] = '{256, 64, 32, 16};

  tbp_timer_out #(.DW(8)) dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cpu_tick(cpu_tick), .event_in(event_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq_req(irq_req));

  // 5 ns clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      err_count++;
      summarize();
    end
  end

  // Compare and report
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle register write
  task wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(negedge clk);
  endtask : wr_reg

  // One-cycle register read, data taken in the following cycle
  task rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg

  // Bounded wait for a pin level
  task wait_pin(input logic v);
    int i;
    i = 0;
    while (pin_out !== v && i < 2000) begin
      @(negedge clk);
      i++;
    end
    chk("pin_out level", 16'(v), 16'(pin_out));
  endtask : wait_pin

  // Cycles from one rising pin edge to the next
  task period(output int p);
    wait_pin(1'b0);
    wait_pin(1'b1);
    p = 0;
    do begin
      @(negedge clk);
      p++;
    end while (pin_out === 1'b1 && p < 2000);
    while (pin_out !== 1'b1 && p < 2000) begin
      @(negedge clk);
      p++;
    end
  endtask : period

  // One falling edge on the event pin
  task pulse_event;
    @(posedge clk);
    event_in <= 1'b1;
    repeat (2) @(posedge clk);
    event_in <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_event

  // Verdict and end of run
  task summarize;
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    resetn = 1'b0; addr = 2'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    cpu_tick = 1'b0; event_in = 1'b0; gpio_out = 1'b1; gpio_oe = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(tbp_pkg::OFF_CTRL, d);
    chk("ctrl reset", 16'(tbp_pkg::CTRL_RST), 16'(d));
    rd_reg(tbp_pkg::OFF_COUNT, d);
    chk("count reset", 16'(tbp_pkg::COUNT_RST), 16'(d));
    rd_reg(tbp_pkg::OFF_STAT, d);
    chk("stat reset", 16'h0000, 16'(d));
    chk("pin idle", 16'h0001, 16'({pin_oe, pin_out}));
    // Event counting, buffered reload at overflow
    wr_reg(tbp_pkg::OFF_CTRL, 8'h06);
    wr_reg(tbp_pkg::OFF_COUNT, 8'hfe);
    wr_reg(tbp_pkg::OFF_RELOAD, 8'h40);
    wr_reg(tbp_pkg::OFF_CTRL, 8'h86);
    pulse_event();
    rd_reg(tbp_pkg::OFF_COUNT, d);
    chk("event count", 16'h00ff, 16'(d));
    rd_reg(tbp_pkg::OFF_RELOAD, d);
    chk("reload read", 16'h0000, 16'(d));
    pulse_event();
    rd_reg(tbp_pkg::OFF_COUNT, d);
    chk("reload at overflow", 16'h0040, 16'(d));
    // Internal slow source ignores events, counts instruction ticks divided by 2
    wr_reg(tbp_pkg::OFF_CTRL, 8'h00);
    wr_reg(tbp_pkg::OFF_COUNT, 8'h00);
    wr_reg(tbp_pkg::OFF_CTRL, 8'hf0);
    pulse_event();
    rd_reg(tbp_pkg::OFF_COUNT, d);
    chk("slow source count", 16'h0000, 16'(d));
    @(posedge clk);
    cpu_tick <= 1'b1;
    repeat (8) @(posedge clk);
    cpu_tick <= 1'b0;
    rd_reg(tbp_pkg::OFF_COUNT, d);
    chk("slow source ticks", 16'h0004, 16'(d));
    // Buzzer on the shared pin
    wr_reg(tbp_pkg::OFF_CTRL, 8'h00);
    wr_reg(tbp_pkg::OFF_STAT, 8'h02);
    wr_reg(tbp_pkg::OFF_CTRL, 8'h7a);
    wr_reg(tbp_pkg::OFF_COUNT, 8'hf0);
    wr_reg(tbp_pkg::OFF_RELOAD, 8'hf0);
    wr_reg(tbp_pkg::OFF_CTRL, 8'hfa);
    chk("pin before buzzer", 16'h0001, 16'({pin_oe, pin_out}));
    wr_reg(tbp_pkg::OFF_CTRL, 8'hfb);
    chk("buzzer pin_oe", 16'h0001, 16'(pin_oe));
    period(n);
    chk("buzzer period", 16'd32, 16'(n));
    rd_reg(tbp_pkg::OFF_STAT, d);
    chk("buzzer stat", 16'h0003, 16'(d));
    chk("buzzer irq", 16'h0001, 16'(irq_req));
    wr_reg(tbp_pkg::OFF_CTRL, 8'hfa);
    chk("buzzer off pin", 16'h0001, 16'({pin_oe, pin_out}));
    rd_reg(tbp_pkg::OFF_COUNT, d);
    rd_reg(tbp_pkg::OFF_COUNT, d2);
    chk("count runs", 16'h0001, 16'(d !== d2));
    // PWM at each resolution
    for (int i = 0; i < 4; i++) begin
      wr_reg(tbp_pkg::OFF_CTRL, 8'h00);
      wr_reg(tbp_pkg::OFF_CTRL, 8'h78 | 8'(i));
      wr_reg(tbp_pkg::OFF_RELOAD, 8'h00);
      wr_reg(tbp_pkg::OFF_COUNT, 8'h00);
      wr_reg(tbp_pkg::OFF_CTRL, 8'hf8 | 8'(i));
      wr_reg(tbp_pkg::OFF_STAT, 8'h04);
      chk("pwm pin_oe", 16'h0001, 16'(pin_oe));
      period(n);
      chk("pwm period", 16'(exp_p[i]), 16'(n));
      rd_reg(tbp_pkg::OFF_STAT, d);
      chk("pwm stat", 16'h0005, 16'(d));
    end
    // Reload change sets the period from the next period on
    wr_reg(tbp_pkg::OFF_RELOAD, 8'h04);
    period(n);
    chk("pwm new period", 16'd12, 16'(n));
    wr_reg(tbp_pkg::OFF_CTRL, 8'h7b);
    chk("pwm stopped pin", 16'h0002, 16'({pin_oe, pin_out}));
    wr_reg(tbp_pkg::OFF_CTRL, 8'hfa);
    wr_reg(tbp_pkg::OFF_STAT, 8'h00);
    chk("pwm off pin", 16'h0001, 16'({pin_oe, pin_out}));
    rd_reg(tbp_pkg::OFF_COUNT, d);
    rd_reg(tbp_pkg::OFF_COUNT, d2);
    chk("count runs", 16'h0001, 16'(d !== d2));
    summarize();
  end
endmodule : tbp_timer_out_bench
`default_nettype wire
